// ===== pkg/i2cms_pkg.sv
// constants and types shared by the two-wire master bus status block
package i2cms_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] OFF_CTRLA  = 3'h0;
  localparam logic [2:0] OFF_MASTER_CONTROL_B = 3'h1;
  localparam logic [2:0] OFF_STATUS = 3'h2;
  localparam logic [2:0] OFF_MASTER_ADDRESS_REG  = 3'h3;
  localparam logic [2:0] OFF_MASTER_DATA_REG  = 3'h4;

  // field positions
  localparam int EN_BIT     = 0;
  localparam int CMD_LSB    = 0;
  localparam int ACKNOWLEDGE_ACTION_BIT = 2;
  localparam int STATE_LSB  = 0;
  localparam int ERR_BIT    = 2;
  localparam int ARB_BIT    = 3;
  localparam int ACK_BIT    = 4;
  localparam int HOLD_BIT   = 5;

  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic       ACK_RST = 1'h0;

  // bus state field encoding
  localparam logic [1:0] ST_UNKNOWN = 2'h0;
  localparam logic [1:0] ST_IDLE    = 2'h1;
  localparam logic [1:0] ST_OWNER   = 2'h2;
  localparam logic [1:0] ST_BUSY    = 2'h3;

  // serial clock rises per byte before the acknowledge clock
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // least ratio of link sampling clock to serial clock
  localparam int OVERSAMPLE = 4;

  // events crossing from the link domain
  localparam int EV_START = 0;
  localparam int EV_STOP  = 1;
  localparam int EV_ERR   = 2;
  localparam int EV_ARB   = 3;
  localparam int EV_ACK   = 4;
  localparam int EV_W     = 5;

  // what the own transmitter is doing on the bus
  typedef enum logic [1:0] {
    I2CMS_TX_NONE  = 2'h0,
    I2CMS_TX_BIT   = 2'h1,
    I2CMS_TX_START = 2'h2
  } i2cms_tx_type;

  // bus monitor states
  typedef enum logic [3:0] {
    I2CMS_UNKNOWN = 4'h1,
    I2CMS_IDLE    = 4'h2,
    I2CMS_OWNER   = 4'h4,
    I2CMS_BUSY    = 4'h8
  } i2cms_bus_type;

endpackage

// ===== verilog/i2cms_master_status.sv
// master-side status flags and bus state monitor of a two-wire controller
//
// Function
// R01: status bit 4 holds last acknowledge, 1=NACK
// R02: set arbitration lost on lost high bit/start
// R03: writing one clears arbitration lost
// R04: master address write clears arbitration lost
// R05: arbitration lost clears like clock hold
// R06: software rewrites address after arbitration loss
// R07: set bus error on illegal start/stop
// R08: writing one clears bus error
// R09: master address write clears bus error
// R10: software treats bus error as ownership lost
// R11: detect errors only while enabled, clock 4x
// R12: bus state field encodes unknown/idle/owner/busy
// R13: bus state unknown after reset or re-enable
// R14: writing idle forces idle, others ignored
// R15: bus state unknown while master disabled
// R16: data write, acked read, command clear hold
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module i2cms_master_status (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET_N,
  input  wire logic       LINK_CLK,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  input  wire logic [1:0] TX_PHASE,
  input  wire logic       TX_SDA_HIGH,
  input  wire logic       MASTER_TX,
  output logic            MASTER_EN,
  output logic      [1:0] BUS_STATE,
  output logic            ARB_LOST,
  output logic            CLOCK_HOLD
);

  // register port address match
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  // one-hot state to field code
  function automatic logic [1:0] enc(input i2cms_pkg::i2cms_bus_type s);
    case (s)
      i2cms_pkg::I2CMS_IDLE:  enc = i2cms_pkg::ST_IDLE;
      i2cms_pkg::I2CMS_OWNER: enc = i2cms_pkg::ST_OWNER;
      i2cms_pkg::I2CMS_BUSY:  enc = i2cms_pkg::ST_BUSY;
      default:                enc = i2cms_pkg::ST_UNKNOWN;
    endcase
  endfunction

  // ---------------- link domain ----------------
  logic            scl_s1_ff;
  logic            scl_s2_ff;
  logic            scl_d_ff;
  logic            sda_s1_ff;
  logic            sda_s2_ff;
  logic            sda_d_ff;
  logic            en_l1_ff;
  logic            en_l2_ff;
  logic      [3:0] bit_cnt_ff;
  logic            in_frame_ff;
  logic            empty_ff;
  logic [i2cms_pkg::EV_W-1:0] ev_tgl_ff;
  logic            ack_val_ff;
  logic            own_start_ff;
  logic            start_det;
  logic            stop_det;
  logic            scl_rise;
  logic            bad_cond;
  logic            arb_det;
  logic            ack_det;

  // pin and enable synchronisers
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_s1_ff <= 1'h1;
      scl_s2_ff <= 1'h1;
      scl_d_ff  <= 1'h1;
      sda_s1_ff <= 1'h1;
      sda_s2_ff <= 1'h1;
      sda_d_ff  <= 1'h1;
      en_l1_ff  <= 1'h0;
      en_l2_ff  <= 1'h0;
    end else begin
      scl_s1_ff <= SCL_IN;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff  <= scl_s2_ff;
      sda_s1_ff <= SDA_IN;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff  <= sda_s2_ff;
      en_l1_ff  <= MASTER_EN;
      en_l2_ff  <= en_l1_ff;
    end
  end

  // condition detection on the synchronised lines
  assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign stop_det  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
  assign scl_rise  = scl_s2_ff & ~scl_d_ff;
  // a legal start or stop sits on the first clock high after an acknowledge;
  // anywhere else in a frame, or before any whole byte, it breaks the protocol
  assign bad_cond  = (start_det | stop_det) & in_frame_ff &
                     ((bit_cnt_ff != 4'h1) | empty_ff);
  // released line seen low while sending a high bit or a start
  assign arb_det   = ~TX_SDA_HIGH ? 1'h0 :
                     (TX_PHASE == i2cms_pkg::I2CMS_TX_BIT) ? (scl_rise & ~sda_s2_ff) :
                     (TX_PHASE == i2cms_pkg::I2CMS_TX_START) ?
                       (scl_s2_ff & ~sda_s2_ff & ~start_det) : 1'h0;
  assign ack_det   = scl_rise & in_frame_ff & (bit_cnt_ff == i2cms_pkg::ACK_SLOT);

  // frame and bit tracking; idle when the monitor is disabled
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bit_cnt_ff  <= 4'h0;
      in_frame_ff <= 1'h0;
      empty_ff    <= 1'h0;
    end else if (!en_l2_ff) begin
      bit_cnt_ff  <= 4'h0;
      in_frame_ff <= 1'h0;
      empty_ff    <= 1'h0;
    end else if (start_det) begin
      bit_cnt_ff  <= 4'h0;
      in_frame_ff <= 1'h1;
      empty_ff    <= 1'h1;
    end else if (stop_det) begin
      bit_cnt_ff  <= 4'h0;
      in_frame_ff <= 1'h0;
      empty_ff    <= 1'h0;
    end else if (scl_rise && in_frame_ff) begin
      if (ack_det)
        empty_ff  <= 1'h0;  // a whole byte has passed since the start
      bit_cnt_ff  <= ack_det ? 4'h0 : bit_cnt_ff + 4'h1;
    end
  end

  // events leave as toggles, data words held stable beside them
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ev_tgl_ff    <= '0;
      ack_val_ff   <= i2cms_pkg::ACK_RST;
      own_start_ff <= 1'h0;
    end else if (en_l2_ff) begin  // see R11
      if (start_det) begin
        ev_tgl_ff[i2cms_pkg::EV_START] <= ~ev_tgl_ff[i2cms_pkg::EV_START];
        own_start_ff <= (TX_PHASE == i2cms_pkg::I2CMS_TX_START);
      end
      if (stop_det)
        ev_tgl_ff[i2cms_pkg::EV_STOP] <= ~ev_tgl_ff[i2cms_pkg::EV_STOP];
      if (bad_cond)  // see R07
        ev_tgl_ff[i2cms_pkg::EV_ERR] <= ~ev_tgl_ff[i2cms_pkg::EV_ERR];
      if (arb_det)  // see R02
        ev_tgl_ff[i2cms_pkg::EV_ARB] <= ~ev_tgl_ff[i2cms_pkg::EV_ARB];
      if (ack_det && MASTER_TX) begin
        ev_tgl_ff[i2cms_pkg::EV_ACK] <= ~ev_tgl_ff[i2cms_pkg::EV_ACK];
        ack_val_ff <= sda_s2_ff;
      end
    end
  end

  // ---------------- system domain ----------------
  logic [i2cms_pkg::EV_W-1:0] ev_s1_ff;
  logic [i2cms_pkg::EV_W-1:0] ev_s2_ff;
  logic [i2cms_pkg::EV_W-1:0] ev_d_ff;
  logic [i2cms_pkg::EV_W-1:0] ev;
  logic                       master_en_ff;
  logic                 [1:0] cmd_ff;
  logic                       acknowledge_action_ff;
  logic                 [7:0] master_address_reg_ff;
  logic                 [7:0] master_data_reg_ff;
  logic                       ack_ff;
  logic                       arb_ff;
  logic                       err_ff;
  logic                       hold_ff;
  logic                 [7:0] rdata_ff;
  logic                 [1:0] field_ff;
  i2cms_pkg::i2cms_bus_type   state_ff;
  i2cms_pkg::i2cms_bus_type   nxt_state;
  logic                       wr_status;
  logic                       wr_master_address_reg;
  logic                       hold_clr;
  logic                       force_idle;

  // event toggle synchronisers and edge pulses
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ev_s1_ff <= '0;
      ev_s2_ff <= '0;
      ev_d_ff  <= '0;
    end else begin
      ev_s1_ff <= ev_tgl_ff;
      ev_s2_ff <= ev_s1_ff;
      ev_d_ff  <= ev_s2_ff;
    end
  end
  assign ev = ev_s2_ff ^ ev_d_ff;

  // register write decode and clearing actions
  assign wr_status  = WR & hit(ADDR, i2cms_pkg::OFF_STATUS);
  assign wr_master_address_reg   = WR & hit(ADDR, i2cms_pkg::OFF_MASTER_ADDRESS_REG);
  assign hold_clr   = (WR & hit(ADDR, i2cms_pkg::OFF_MASTER_DATA_REG)) |
                      (RD & hit(ADDR, i2cms_pkg::OFF_MASTER_DATA_REG) & acknowledge_action_ff) |
                      (WR & hit(ADDR, i2cms_pkg::OFF_MASTER_CONTROL_B) &
                       (WDATA[i2cms_pkg::CMD_LSB +: 2] != 2'h0));  // see R16
  assign force_idle = wr_status &
                      (WDATA[i2cms_pkg::STATE_LSB +: 2] == i2cms_pkg::ST_IDLE);

  // control and data registers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      master_en_ff <= 1'h0;
      cmd_ff       <= 2'h0;
      acknowledge_action_ff    <= 1'h0;
      master_address_reg_ff     <= i2cms_pkg::REG_RST;
      master_data_reg_ff     <= i2cms_pkg::REG_RST;
    end else if (WR) begin
      if (hit(ADDR, i2cms_pkg::OFF_CTRLA))
        master_en_ff <= WDATA[i2cms_pkg::EN_BIT];
      else if (hit(ADDR, i2cms_pkg::OFF_MASTER_CONTROL_B)) begin
        cmd_ff    <= WDATA[i2cms_pkg::CMD_LSB +: 2];
        acknowledge_action_ff <= WDATA[i2cms_pkg::ACKNOWLEDGE_ACTION_BIT];
      end else if (hit(ADDR, i2cms_pkg::OFF_MASTER_ADDRESS_REG))
        master_address_reg_ff <= WDATA;
      else if (hit(ADDR, i2cms_pkg::OFF_MASTER_DATA_REG))
        master_data_reg_ff <= WDATA;
    end
  end

  // last acknowledge received
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      ack_ff <= i2cms_pkg::ACK_RST;
    else if (ev[i2cms_pkg::EV_ACK])
      ack_ff <= ack_val_ff;  // see R01
  end

  // arbitration lost: set wins over every clear
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      arb_ff <= 1'h0;
    else if (ev[i2cms_pkg::EV_ARB])
      arb_ff <= 1'h1;  // see R02
    else if (wr_status && WDATA[i2cms_pkg::ARB_BIT])
      arb_ff <= 1'h0;  // see R03
    else if (wr_master_address_reg || hold_clr)
      arb_ff <= 1'h0;  // see R04 see R05 see R06
  end

  // bus error: set wins over every clear
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      err_ff <= 1'h0;
    else if (ev[i2cms_pkg::EV_ERR])
      err_ff <= 1'h1;  // see R07
    else if (wr_status && WDATA[i2cms_pkg::ERR_BIT])
      err_ff <= 1'h0;  // see R08
    else if (wr_master_address_reg)
      err_ff <= 1'h0;  // see R09 see R10
  end

  // clock hold after an own byte or a lost arbitration
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      hold_ff <= 1'h0;
    else if (ev[i2cms_pkg::EV_ARB] ||
             (ev[i2cms_pkg::EV_ACK] && state_ff == i2cms_pkg::I2CMS_OWNER))
      hold_ff <= 1'h1;
    else if (wr_master_address_reg || hold_clr)
      hold_ff <= 1'h0;  // see R16
  end

  // bus monitor next state
  always_comb begin
    nxt_state = state_ff;
    if (!master_en_ff)
      nxt_state = i2cms_pkg::I2CMS_UNKNOWN;  // see R13 see R15
    else if (force_idle)
      nxt_state = i2cms_pkg::I2CMS_IDLE;  // see R14
    else if (ev[i2cms_pkg::EV_STOP])
      nxt_state = i2cms_pkg::I2CMS_IDLE;
    else if (ev[i2cms_pkg::EV_START])
      nxt_state = own_start_ff ? i2cms_pkg::I2CMS_OWNER : i2cms_pkg::I2CMS_BUSY;
    else if (ev[i2cms_pkg::EV_ARB] && state_ff == i2cms_pkg::I2CMS_OWNER)
      nxt_state = i2cms_pkg::I2CMS_BUSY;
  end

  // bus monitor state and its field code
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= i2cms_pkg::I2CMS_UNKNOWN;  // see R13
      field_ff <= i2cms_pkg::ST_UNKNOWN;
    end else begin
      state_ff <= nxt_state;
      field_ff <= enc(nxt_state);  // see R12
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      rdata_ff <= 8'h00;
    else if (!RD)
      rdata_ff <= 8'h00;
    else if (hit(ADDR, i2cms_pkg::OFF_CTRLA))
      rdata_ff <= {7'h00, master_en_ff};
    else if (hit(ADDR, i2cms_pkg::OFF_MASTER_CONTROL_B))
      rdata_ff <= {5'h00, acknowledge_action_ff, cmd_ff};
    else if (hit(ADDR, i2cms_pkg::OFF_STATUS))
      rdata_ff <= {2'h0, hold_ff, ack_ff, arb_ff, err_ff, field_ff};
    else if (hit(ADDR, i2cms_pkg::OFF_MASTER_ADDRESS_REG))
      rdata_ff <= master_address_reg_ff;
    else if (hit(ADDR, i2cms_pkg::OFF_MASTER_DATA_REG))
      rdata_ff <= master_data_reg_ff;
    else
      rdata_ff <= 8'h00;
  end

  assign RDATA      = rdata_ff;
  assign MASTER_EN  = master_en_ff;
  assign BUS_STATE  = field_ff;
  assign ARB_LOST   = arb_ff;
  assign CLOCK_HOLD = hold_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  ack_capture_a: assert property (ev[i2cms_pkg::EV_ACK] |=> ack_ff == $past(ack_val_ff))
    else $error("acknowledge not captured");  // see R01
  arb_set_a: assert property (ev[i2cms_pkg::EV_ARB] |=> ARB_LOST && CLOCK_HOLD)
    else $error("arbitration loss not flagged");  // see R02
  arb_w1c_a: assert property (wr_status && WDATA[i2cms_pkg::ARB_BIT] &&
                              !ev[i2cms_pkg::EV_ARB] |=> !ARB_LOST)
    else $error("arbitration flag not cleared by one");  // see R03
  arb_addr_clear_a: assert property (wr_master_address_reg && !ev[i2cms_pkg::EV_ARB] |=> !ARB_LOST)
    else $error("address write left arbitration flag");  // see R04
  hold_clear_a: assert property (hold_clr && !ev[i2cms_pkg::EV_ARB] && !ev[i2cms_pkg::EV_ACK]
                                 |=> !ARB_LOST && !CLOCK_HOLD)
    else $error("hold clear missed a flag");  // see R05
  err_set_a: assert property (ev[i2cms_pkg::EV_ERR] |=> err_ff)
    else $error("bus error not flagged");  // see R07
  err_w1c_a: assert property (wr_status && WDATA[i2cms_pkg::ERR_BIT] &&
                              !ev[i2cms_pkg::EV_ERR] |=> !err_ff)
    else $error("bus error not cleared by one");  // see R08
  err_addr_clear_a: assert property (wr_master_address_reg && !ev[i2cms_pkg::EV_ERR] |=> !err_ff)
    else $error("address write left bus error");  // see R09
  field_code_a: assert property ($onehot(state_ff) &&
                                 ((state_ff == i2cms_pkg::I2CMS_BUSY) ==
                                  (BUS_STATE == i2cms_pkg::ST_BUSY)))
    else $error("bus state field out of step");  // see R12
  enable_unknown_a: assert property ($rose(master_en_ff) && !force_idle && ev == '0 |->
                                     BUS_STATE == i2cms_pkg::ST_UNKNOWN ##1
                                     BUS_STATE == i2cms_pkg::ST_UNKNOWN)
    else $error("state not unknown at enable");  // see R13
  force_idle_a: assert property (master_en_ff && force_idle |=> BUS_STATE == i2cms_pkg::ST_IDLE)
    else $error("idle force ignored");  // see R14
  force_other_a: assert property (master_en_ff && wr_status && !force_idle && ev == '0 &&
                                  state_ff == i2cms_pkg::I2CMS_UNKNOWN |=> $stable(BUS_STATE))
    else $error("bus state forced to non-idle");  // see R14
  disabled_a: assert property (!master_en_ff |=> BUS_STATE == i2cms_pkg::ST_UNKNOWN ##1
                               ($past(master_en_ff) || BUS_STATE == i2cms_pkg::ST_UNKNOWN))
    else $error("state known while disabled");  // see R15

  own_start_c: cover property (master_en_ff && ev[i2cms_pkg::EV_START] && own_start_ff);
  arb_loss_c: cover property (state_ff == i2cms_pkg::I2CMS_OWNER && ev[i2cms_pkg::EV_ARB]);
  bus_error_c: cover property (ev[i2cms_pkg::EV_ERR] ##[1:20] wr_master_address_reg);
  nack_c: cover property (ev[i2cms_pkg::EV_ACK] && ack_val_ff);

endmodule

// ===== tb/i2cms_bus_model.sv
// far side of the two-wire bus, plus the own transmitter's phase lines
`timescale 1ns/1ps
module i2cms_bus_model (
  input  wire logic       link_clk,
  output logic            scl,
  output logic            sda,
  output logic      [1:0] tx_phase,
  output logic            tx_sda_high,
  output logic            master_tx
);
  // released lines rest at the pull-up, serial clock stands still
  initial begin
    scl = 1'h1;
    sda = 1'h1;
    tx_phase = 2'h0;
    tx_sda_high = 1'h1;
    master_tx = 1'h0;
  end
  // one bus level, held long enough for the oversampling pin sync
  task automatic step(input logic c, input logic d, input logic own);
    @(posedge link_clk);
    scl <= c;
    sda <= d & own; // wired-and of the other party and the own driver
    tx_sda_high <= own;
    repeat (2) @(posedge link_clk);
  endtask
  // start: data falls while the serial clock is high
  task automatic start(input logic own);
    tx_phase <= own ? 2'h2 : 2'h0;
    step(1'h1, 1'h1, 1'h1);
    step(1'h1, own, ~own);
    step(1'h0, own, ~own);
    tx_phase <= 2'h0;
  endtask
  // own start lost: another party pulls data low while ours is released
  task automatic start_lost;
    tx_phase <= 2'h2;
    step(1'h1, 1'h1, 1'h1);
    step(1'h1, 1'h0, 1'h1);
    step(1'h0, 1'h0, 1'h1);
    tx_phase <= 2'h0;
  endtask
  // one data bit, sampled at the serial clock rise
  task automatic bit_xfer(input logic tx, input logic own, input logic d, input logic mtx);
    tx_phase <= {1'h0, tx};
    master_tx <= mtx;
    step(1'h0, d, own);
    step(1'h1, d, own);
    step(1'h0, d, own);
  endtask
  // eight data bits then the acknowledge slot driven by the other party
  task automatic byte_xfer(input logic tx, input logic [7:0] own, input logic [7:0] d,
                           input logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(tx, own[i], d[i], tx);
    end
    bit_xfer(1'h0, 1'h1, ack, tx);
  endtask
  // stop: data rises while the serial clock is high
  task automatic stop;
    tx_phase <= 2'h0;
    master_tx <= 1'h0;
    step(1'h0, 1'h0, 1'h1);
    step(1'h1, 1'h0, 1'h1);
    step(1'h1, 1'h1, 1'h1);
  endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the master bus status block
`timescale 1ns/1ps
module tb;
  logic       sys_clk;
  logic       reset_n;
  logic       link_clk;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] rdata;
  logic       scl;
  logic       sda;
  logic [1:0] tx_phase;
  logic       tx_sda_high;
  logic       master_tx;
  logic       master_en;
  logic [1:0] bus_state;
  logic       arb_lost;
  logic       clock_hold;
  logic [7:0] d;
  int         n_errors;
  int         comparisons;

  i2cms_master_status u_dut (
    .SYS_CLK     (sys_clk),
    .RESET_N     (reset_n),
    .LINK_CLK    (link_clk),
    .ADDR        (addr),
    .WDATA       (wdata),
    .WR          (wr_s),
    .RD          (rd_s),
    .RDATA       (rdata),
    .SCL_IN      (scl),
    .SDA_IN      (sda),
    .TX_PHASE    (tx_phase),
    .TX_SDA_HIGH (tx_sda_high),
    .MASTER_TX   (master_tx),
    .MASTER_EN   (master_en),
    .BUS_STATE   (bus_state),
    .ARB_LOST    (arb_lost),
    .CLOCK_HOLD  (clock_hold)
  );
  i2cms_bus_model u_bus (
    .link_clk    (link_clk),
    .scl         (scl),
    .sda         (sda),
    .tx_phase    (tx_phase),
    .tx_sda_high (tx_sda_high),
    .master_tx   (master_tx)
  );

  // system clock 100 MHz
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // link clock 80 ns, phase offset from the system clock
  initial begin
    link_clk = 1'h0;
    #3;
    forever #40 link_clk = ~link_clk;
  end
  // register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    wr_s <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr_s <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    rd_s <= 1'h1;
    addr <= a;
    @(posedge sys_clk);
    rd_s <= 1'h0;
    #1;
    v = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // status register helpers
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(i2cms_pkg::OFF_STATUS, v);
    chk(v & m, e);
  endtask
  task automatic ws(input logic [7:0] v);
    wr(i2cms_pkg::OFF_STATUS, v);
  endtask
  // lets a bus event cross pin sync and the domain crossing
  task automatic settle;
    repeat (4) @(posedge link_clk);
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #600000;
    n_errors++;
    complete_run;
  end
  // reset held over the slower link clock so both domains see it
  initial begin
    n_errors = 0;
    comparisons = 0;
    reset_n = 1'h0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_s = 1'h0;
    rd_s = 1'h0;
    repeat (8) @(posedge link_clk);
    @(posedge sys_clk);
    reset_n <= 1'h1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      chk(d, 8'h00);
    end
    $display("test 1 done");
    // disabled: nothing detected, forcing idle ignored
    ws(8'h01);
    u_bus.start(1'h0);
    u_bus.stop;
    settle;
    st(8'hff, 8'h00);
    wr(i2cms_pkg::OFF_CTRLA, 8'h01);
    st(8'hff, 8'h00);
    ws(8'h02);
    st(8'h03, 8'h00);
    ws(8'h01);
    st(8'h03, 8'h01);
    wr(i2cms_pkg::OFF_MASTER_ADDRESS_REG, 8'h5a);
    wr(3'h6, 8'hff);
    rd(i2cms_pkg::OFF_MASTER_ADDRESS_REG, d);
    chk(d, 8'h5a);
    rd(3'h6, d);
    chk(d, 8'h00);
    $display("test 2 done");
    // own transfer: nack then ack captured, hold on own ack slot
    u_bus.start(1'h1);
    settle;
    chk({6'h0, bus_state}, {6'h0, i2cms_pkg::ST_OWNER});
    u_bus.byte_xfer(1'h1, 8'ha5, 8'hff, 1'h1);
    settle;
    st(8'h33, 8'h32);
    wr(i2cms_pkg::OFF_MASTER_DATA_REG, 8'h3c);
    chk({7'h0, clock_hold}, 8'h00);
    u_bus.byte_xfer(1'h1, 8'h5a, 8'hff, 1'h0);
    settle;
    st(8'h13, 8'h02);
    u_bus.stop;
    settle;
    st(8'h03, 8'h01);
    $display("test 3 done");
    // foreign transfer: busy, only idle may be forced
    u_bus.start(1'h0);
    settle;
    st(8'h03, 8'h03);
    ws(8'h02);
    st(8'h03, 8'h03);
    u_bus.byte_xfer(1'h0, 8'hff, 8'h3c, 1'h1);
    settle;
    st(8'h13, 8'h03);
    ws(8'h01);
    st(8'h03, 8'h01);
    u_bus.stop;
    $display("test 4 done");
    // arbitration lost on a high bit, cleared each way in turn
    for (int k = 0; k < 5; k++) begin
      u_bus.start(1'h1);
      u_bus.byte_xfer(1'h1, 8'h80, 8'h00, 1'h1);
      u_bus.stop;
      settle;
      st(8'h0f, 8'h09);
      ws(8'h01);
      chk({7'h0, arb_lost}, 8'h01);
      case (k)
        0: ws(8'h08);
        1: wr(i2cms_pkg::OFF_MASTER_ADDRESS_REG, 8'h00);
        2: wr(i2cms_pkg::OFF_MASTER_DATA_REG, 8'h00);
        3: wr(i2cms_pkg::OFF_MASTER_CONTROL_B, 8'h01);
        default: begin
          wr(i2cms_pkg::OFF_MASTER_CONTROL_B, 8'h04);
          rd(i2cms_pkg::OFF_MASTER_DATA_REG, d);
        end
      endcase
      chk({6'h0, arb_lost, clock_hold & (k != 0)}, 8'h00);
    end
    $display("test 5 done");
    // start directly followed by stop is an illegal condition
    for (int k = 0; k < 2; k++) begin
      u_bus.start(1'h0);
      u_bus.stop;
      settle;
      st(8'h07, 8'h05);
      if (k == 0) begin
        ws(8'h04);
      end else begin
        wr(i2cms_pkg::OFF_MASTER_ADDRESS_REG, 8'h11);
      end
      st(8'h04, 8'h00);
    end
    $display("test 6 done");
    // disabling mid-frame gives unknown one cycle later, re-enable stays unknown
    u_bus.start(1'h0);
    settle;
    wr(i2cms_pkg::OFF_CTRLA, 8'h00);
    chk({7'h0, master_en}, 8'h00);
    @(posedge sys_clk);
    #1;
    chk({6'h0, bus_state}, 8'h00);
    u_bus.stop;
    wr(i2cms_pkg::OFF_CTRLA, 8'h01);
    settle;
    st(8'h03, 8'h00);
    $display("test 7 done");
    // own start lost to another party, then a stop with no whole byte
    u_bus.start_lost;
    u_bus.stop;
    settle;
    st(8'h0f, 8'h0d);
    wr(i2cms_pkg::OFF_MASTER_ADDRESS_REG, 8'h22);
    st(8'h2c, 8'h00);
    $display("test 8 done");
    complete_run;
  end
endmodule
